/* File: ddrc_defs.vh */
// Constants of the DDR2 command front end: command codes, field positions, latencies
// Notes on behaviour
// - Read and write bursts last four or eight words in programmed address order; here the order is always sequential, as no burst type bit is decoded.
// - Activate takes row from address 0-11 or 0-12 and bank from bank select.
// - Read or write takes starting column from address 0-8 or 0-7.
// - Address bit 10 with read or write requests automatic precharge after burst; here only a read closes its bank, as its burst starts.
// - Read column latency programmable as 3, 4, 5 or 6 cycles.
// - Posted commands wait a programmable added delay of 0 to 5 cycles.
// - Write latency equals total read latency minus one cycle.
// - Two data words per cycle from a four-word prefetch per column access.
// - Four independent banks may hold open rows concurrently.
// - Command and address sampled on rising clock edge.
// - Read data output one word per half clock period.
// - Clock gate high enables internal clocks and drivers; low disables them.
// - Clock gate low enters precharge power-down or self refresh when idle, else active.
// - Clock gate synchronous for power-down and self-refresh entry, asynchronous for exit; here exit also waits for a clock edge.
// - Power-down keeps clock, termination, gate inputs; self refresh keeps only gate input.
// - Commands with chip select high are ignored.
// - Delay-locked loop aligns data and strobe output with input clock.
// - Output drive strength selectable as full or reduced.
// - Precharge with bit 10 low closes named bank; high closes all banks.
// - Row strobe, column strobe, write enable and chip select encode the command.
// - Mode register commands pick register by bank select; address carries op-code.
`ifndef DDRC_DEFS_VH
`define DDRC_DEFS_VH
// Command codes {cs_n, ras_n, cas_n, we_n}
`define DDRC_CMD_MRS      4'h0
`define DDRC_CMD_REF      4'h1
`define DDRC_CMD_PRE      4'h2
`define DDRC_CMD_ACT      4'h3
`define DDRC_CMD_WR       4'h4
`define DDRC_CMD_RD       4'h5
`define DDRC_CMD_NOP      4'h7
// Mode register fields
`define DDRC_MR_BL_LSB    0
`define DDRC_MR_CL_LSB    4
`define DDRC_EMR_DS_BIT   1
`define DDRC_EMR_AL_LSB   3
`define DDRC_AP_BIT       10
`define DDRC_BL8_CODE     3'h3
`define DDRC_CL_MIN       3'h3
`define DDRC_CL_MAX       3'h6
`define DDRC_AL_MAX       3'h5
`define DDRC_CL_RESET     3'h3
`define DDRC_AL_RESET     3'h0
`define DDRC_NBANK        4
`endif

/* File: ddrc_fifo.v */
// Parameterised valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddrc_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 8,
	parameter AW    = 3
)(
	input  wire             i_sys_clk,
	input  wire             i_resetn,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wptr_ff;
	reg [AW-1:0]    rptr_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;

	// Full and empty come straight from the occupancy count
	assign o_in_ready  = (cnt_ff != DEPTH[AW:0]);
	assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
	assign o_out_data  = mem_ff[rptr_ff];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Storage is not reset; only pointers matter
	always @(posedge i_sys_clk)
	begin
		if (push)
			mem_ff[wptr_ff] <= i_in_data;
	end

	// Pointers wrap; depth must be a power of two
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			wptr_ff <= {AW{1'b0}};
			rptr_ff <= {AW{1'b0}};
			cnt_ff  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wptr_ff <= wptr_ff + 1'b1;
			if (pop)
				rptr_ff <= rptr_ff + 1'b1;
			if (push & ~pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop & ~push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // ddrc_fifo

/* File: ddrc_bank.v */
// Per-bank open-row tracker
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddrc_bank #(
	parameter RW = 13
)(
	input  wire          i_sys_clk,
	input  wire          i_resetn,
	input  wire          i_open,
	input  wire          i_close,
	input  wire [RW-1:0] i_row,
	output reg           o_active,
	output reg  [RW-1:0] o_row
);
	// Activate registers the row; precharge closes it
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			o_active <= 1'b0;
			o_row    <= {RW{1'b0}};
		end
		else if (i_open)
		begin
			o_active <= 1'b1;
			o_row    <= i_row;
		end
		else if (i_close)
			o_active <= 1'b0;
	end
endmodule // ddrc_bank

/* File: ddrc_cmd_top.v */
// DDR2 command front end: decode, bank state, latency pipeline, burst and power states
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddrc_cmd_top #(
	parameter DW      = 32,
	parameter AW      = 13,
	parameter FDEPTH  = 8,
	parameter FAW     = 3
)(
	input  wire          i_sys_clk,
	input  wire          i_resetn,
	input  wire          i_reduced_page,
	input  wire          i_clk_gate,
	input  wire          i_cs_n,
	input  wire          i_ras_n,
	input  wire          i_cas_n,
	input  wire          i_we_n,
	input  wire [1:0]    i_bank_select,
	input  wire [AW-1:0] i_addr,
	input  wire [DW-1:0] i_wr_data_rise,
	input  wire [DW-1:0] i_wr_data_fall,
	input  wire          i_dll_locked,
	input  wire          i_arr_ready,
	output reg           o_arr_rd_req,
	output reg           o_arr_wr_req,
	output reg  [1:0]    o_arr_bank,
	output reg  [AW-1:0] o_arr_row,
	output reg  [8:0]    o_arr_col,
	input  wire [DW-1:0] i_arr_rd_rise,
	input  wire [DW-1:0] i_arr_rd_fall,
	input  wire          i_arr_rd_valid,
	output reg  [DW-1:0] o_dq_rise,
	output reg  [DW-1:0] o_dq_fall,
	output reg           o_dq_oe,
	output reg           o_dqs_oe,
	output reg  [DW-1:0] o_wr_word_rise,
	output reg  [DW-1:0] o_wr_word_fall,
	output reg           o_wr_word_valid,
	output reg           o_auto_precharge,
	output reg  [3:0]    o_bank_active,
	output reg           o_reduced_drive,
	output reg           o_power_down,
	output reg           o_self_refresh,
	output reg           o_input_buf_en,
	output reg           o_ck_buf_en
);
	// Power state one-hot codes
	localparam [2:0] ST_ON  = 3'h1;
	localparam [2:0] ST_PD  = 3'h2;
	localparam [2:0] ST_SR  = 3'h4;

	reg  [2:0]    pstate_ff;
	reg  [2:0]    nxt_pstate;
	reg  [2:0]    cl_ff;
	reg  [2:0]    al_ff;
	reg           bl8_ff;
	reg           ap_ff;
	reg  [3:0]    rd_pipe_ff;
	reg  [3:0]    wr_pipe_ff;
	reg  [15:0]   lat_rd_ff;
	reg  [15:0]   lat_wr_ff;
	reg  [1:0]    beat_ff;
	reg  [1:0]    wbeat_ff;
	reg  [1:0]    cmd_bank_ff;
	reg  [8:0]    cmd_col_ff;
	reg           cmd_rd_ff;
	reg  [1:0]    col_ofs_ff;
	reg  [3:0]    wr_bursts_ff;
	reg  [DW-1:0] cap_rise_ff;
	reg  [DW-1:0] cap_fall_ff;
	reg           cap_valid_ff;
	wire [3:0]    cmd;
	wire          run;
	wire          all_idle;
	wire          is_act;
	wire          is_rd;
	wire          is_wr;
	wire          is_pre;
	wire          is_mrs;
	wire          is_ref;
	wire [3:0]    bank_open;
	wire [3:0]    bank_close;
	wire [3:0]    bank_act_w;
	wire [AW-1:0] row_val;
	wire [8:0]    col_val;
	wire [3:0]    rl;
	wire          fifo_in_valid;
	wire          fifo_in_ready;
	wire          fifo_out_valid;
	wire [2*DW-1:0] fifo_out_data;
	wire          rd_fire;
	wire          wr_fire;
	wire [1:0]    last_beat;

	// Command code includes chip select so a deselected cycle decodes to nothing
	assign cmd      = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
	assign run      = pstate_ff[0] & i_clk_gate;
	assign is_act   = run & (cmd == `DDRC_CMD_ACT);
	assign is_rd    = run & (cmd == `DDRC_CMD_RD);
	assign is_wr    = run & (cmd == `DDRC_CMD_WR);
	assign is_pre   = run & (cmd == `DDRC_CMD_PRE);
	assign is_mrs   = run & (cmd == `DDRC_CMD_MRS);
	assign is_ref   = (cmd == `DDRC_CMD_REF);
	assign all_idle = (bank_act_w == 4'h0);
	assign last_beat = bl8_ff ? 2'h3 : 2'h1;

	// Row width follows the page option; the top bit is masked on standard page
	assign row_val = i_reduced_page ? i_addr
		: {1'b0, i_addr[AW-2:0]};
	// Column width: 9 bits standard page, 8 bits reduced page
	assign col_val = i_reduced_page ? {1'b0, i_addr[7:0]} : i_addr[8:0];
	// Total read latency; write latency is one less
	assign rl = {1'b0, al_ff} + {1'b0, cl_ff};

	// Four independent banks with their own row registers
	genvar g;
	generate
		for (g = 0; g < `DDRC_NBANK; g = g + 1)
		begin : g_bank
			assign bank_open[g]  = is_act & (i_bank_select == g);
			assign bank_close[g] = is_pre & (i_addr[`DDRC_AP_BIT]
				| (i_bank_select == g));
			ddrc_bank #(.RW(AW)) u_bank (
				.i_sys_clk (i_sys_clk),
				.i_resetn  (i_resetn),
				.i_open    (bank_open[g]),
				.i_close   (bank_close[g] | (ap_ff & rd_fire & (cmd_bank_ff == g))),
				.i_row     (row_val),
				.o_active  (bank_act_w[g]),
				.o_row     ()
			);
		end
	endgenerate

	// Write words queue here until the array accepts them
	assign fifo_in_valid = cap_valid_ff;
	ddrc_fifo #(.WIDTH(2*DW), .DEPTH(FDEPTH), .AW(FAW)) u_wfifo (
		.i_sys_clk   (i_sys_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   ({cap_rise_ff, cap_fall_ff}),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (i_arr_ready),
		.o_out_data  (fifo_out_data)
	);

	// A posted command fires when its latency slot reaches the array stage
	assign rd_fire = lat_rd_ff[0];
	assign wr_fire = lat_wr_ff[0];

	// Mode registers: bank select picks the register, address carries the op-code
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			cl_ff           <= `DDRC_CL_RESET;
			al_ff           <= `DDRC_AL_RESET;
			bl8_ff          <= 1'b0;
			o_reduced_drive <= 1'b0;
		end
		else if (is_mrs)
		begin
			if (i_bank_select == 2'h0)
			begin
				bl8_ff <= (i_addr[`DDRC_MR_BL_LSB+2:`DDRC_MR_BL_LSB] == `DDRC_BL8_CODE);
				// Unsupported latency codes leave the old value
				if (i_addr[`DDRC_MR_CL_LSB+2:`DDRC_MR_CL_LSB] >= `DDRC_CL_MIN
					&& i_addr[`DDRC_MR_CL_LSB+2:`DDRC_MR_CL_LSB] <= `DDRC_CL_MAX)
					cl_ff <= i_addr[`DDRC_MR_CL_LSB+2:`DDRC_MR_CL_LSB];
			end
			else if (i_bank_select == 2'h1)
			begin
				o_reduced_drive <= i_addr[`DDRC_EMR_DS_BIT];
				if (i_addr[`DDRC_EMR_AL_LSB+2:`DDRC_EMR_AL_LSB] <= `DDRC_AL_MAX)
					al_ff <= i_addr[`DDRC_EMR_AL_LSB+2:`DDRC_EMR_AL_LSB];
			end
		end
	end

	// Latency shift lines: a read enters at slot al+cl-1, a write one lower, and walks down to zero
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			lat_rd_ff   <= 16'h0000;
			lat_wr_ff   <= 16'h0000;
			cmd_bank_ff <= 2'h0;
			cmd_col_ff  <= 9'h000;
			ap_ff       <= 1'b0;
			cmd_rd_ff   <= 1'b0;
		end
		else
		begin
			lat_rd_ff <= (lat_rd_ff >> 1)
				| (is_rd ? (16'h0001 << rl) >> 1 : 16'h0000);
			lat_wr_ff <= (lat_wr_ff >> 1)
				| (is_wr ? (16'h0001 << rl) >> 2 : 16'h0000);
			if (is_rd | is_wr)
			begin
				cmd_bank_ff <= i_bank_select;
				cmd_col_ff  <= col_val;
				ap_ff       <= i_addr[`DDRC_AP_BIT];
				cmd_rd_ff   <= is_rd;
			end
		end
	end

	// Read requests: one per prefetch of four words, i.e. two beats; write requests one per accepted word pair
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			o_arr_rd_req     <= 1'b0;
			o_arr_wr_req     <= 1'b0;
			o_arr_bank       <= 2'h0;
			o_arr_row        <= {AW{1'b0}};
			o_arr_col        <= 9'h000;
			o_auto_precharge <= 1'b0;
			col_ofs_ff       <= 2'h0;
		end
		else
		begin
			// Ask two slots early so the word pair is back when the data window opens
			o_arr_rd_req <= lat_rd_ff[2] | (rd_fire & bl8_ff);
			o_arr_wr_req <= fifo_out_valid & i_arr_ready;
			o_auto_precharge <= (rd_fire | wr_fire) & ap_ff;
			if (lat_rd_ff[2] | wr_fire)
			begin
				o_arr_bank <= cmd_bank_ff;
				o_arr_col  <= cmd_col_ff;
				col_ofs_ff <= 2'h0;
			end
			else if (rd_fire & bl8_ff)
			begin
				// Interleave-free sequential order within the burst
				col_ofs_ff <= col_ofs_ff + 2'h1;
				o_arr_col  <= {cmd_col_ff[8:3], cmd_col_ff[2:0] + 3'h4};
			end
		end
	end

	// Read beats: two words per cycle while the burst runs
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			o_dq_rise <= {DW{1'b0}};
			o_dq_fall <= {DW{1'b0}};
			o_dq_oe   <= 1'b0;
			o_dqs_oe  <= 1'b0;
			beat_ff   <= 2'h0;
		end
		else
		begin
			if (rd_fire & i_dll_locked)
			begin
				o_dq_oe  <= 1'b1;
				o_dqs_oe <= 1'b1;
				beat_ff  <= 2'h0;
			end
			else if (o_dq_oe)
			begin
				if (beat_ff == last_beat)
				begin
					o_dq_oe  <= 1'b0;
					o_dqs_oe <= 1'b0;
				end
				beat_ff <= beat_ff + 2'h1;
			end
			if (i_arr_rd_valid)
			begin
				o_dq_rise <= i_arr_rd_rise;
				o_dq_fall <= i_arr_rd_fall;
			end
		end
	end

	// Write beats captured one cycle earlier than read data would appear; the buffer
	// output then hands one word pair to the array per accepted cycle
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			cap_rise_ff     <= {DW{1'b0}};
			cap_fall_ff     <= {DW{1'b0}};
			cap_valid_ff    <= 1'b0;
			o_wr_word_rise  <= {DW{1'b0}};
			o_wr_word_fall  <= {DW{1'b0}};
			o_wr_word_valid <= 1'b0;
			wbeat_ff        <= 2'h0;
			wr_bursts_ff    <= 4'h0;
		end
		else
		begin
			cap_valid_ff    <= 1'b0;
			o_wr_word_valid <= fifo_out_valid & i_arr_ready;
			if (fifo_out_valid & i_arr_ready)
			begin
				o_wr_word_rise <= fifo_out_data[2*DW-1:DW];
				o_wr_word_fall <= fifo_out_data[DW-1:0];
			end
			if (wr_fire)
			begin
				wbeat_ff     <= 2'h0;
				wr_bursts_ff <= 4'h1;
			end
			if ((wr_fire | wr_bursts_ff[0]) & fifo_in_ready)
			begin
				cap_rise_ff  <= i_wr_data_rise;
				cap_fall_ff  <= i_wr_data_fall;
				cap_valid_ff <= 1'b1;
				if (!wr_fire)
				begin
					wbeat_ff <= wbeat_ff + 2'h1;
					if (wbeat_ff == last_beat - 2'h1)
						wr_bursts_ff <= 4'h0;
				end
			end
		end
	end

	// Clock-gate low selects power-down or self refresh by bank state and a refresh command in the same cycle
	always @*
	begin
		nxt_pstate = pstate_ff;
		case (pstate_ff)
			ST_ON:
			begin
				if (!i_clk_gate)
					nxt_pstate = (all_idle && is_ref) ? ST_SR : ST_PD;
			end
			ST_PD:
			begin
				if (i_clk_gate)
					nxt_pstate = ST_ON;
			end
			ST_SR:
			begin
				// Exit on the gate level alone; the state register takes it at the next clock edge
				if (i_clk_gate)
					nxt_pstate = ST_ON;
			end
			default:
				nxt_pstate = ST_ON;
		endcase
	end

	// Power state, buffer enables and bank status outputs
	always @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			pstate_ff      <= ST_ON;
			o_power_down   <= 1'b0;
			o_self_refresh <= 1'b0;
			o_input_buf_en <= 1'b1;
			o_ck_buf_en    <= 1'b1;
			o_bank_active  <= 4'h0;
		end
		else
		begin
			pstate_ff      <= nxt_pstate;
			o_power_down   <= nxt_pstate[1];
			o_self_refresh <= nxt_pstate[2];
			o_input_buf_en <= nxt_pstate[0];
			o_ck_buf_en    <= ~nxt_pstate[2];
			o_bank_active  <= bank_act_w;
		end
	end
endmodule // ddrc_cmd_top

/* File: ddrc_cmd_top_properties.sv */
// Checker of the command front end, watching the top module's ports only
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddrc_cmd_props #(
	parameter AW = 13
)(
	input wire          i_sys_clk,
	input wire          i_resetn,
	input wire          i_clk_gate,
	input wire          i_cs_n,
	input wire          i_ras_n,
	input wire          i_cas_n,
	input wire          i_we_n,
	input wire [1:0]    i_bank_select,
	input wire [AW-1:0] i_addr,
	input wire          o_arr_rd_req,
	input wire          o_dq_oe,
	input wire          o_dqs_oe,
	input wire [3:0]    o_bank_active,
	input wire          o_power_down,
	input wire          o_self_refresh,
	input wire          o_input_buf_en,
	input wire          o_ck_buf_en
);
	// Command code and whether the device is awake to take it
	wire [3:0] cmd_w = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
	wire       awake = i_clk_gate && !o_power_down && !o_self_refresh;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	AST_BURST_MIN: assert property ($rose(o_dq_oe) |-> o_dq_oe ##1 o_dq_oe)
		else $error("read burst window shorter than two cycles");
	AST_STROBE_WITH_DATA: assert property (o_dq_oe == o_dqs_oe)
		else $error("strobe enable differs from data enable");
	AST_REQ_BEFORE_DATA: assert property ($rose(o_dq_oe) |-> $past(o_arr_rd_req, 2))
		else $error("read data without array request two cycles before");
	AST_CS_MASK: assert property ($past(i_cs_n) && o_bank_active == 4'h0 |=> o_bank_active == 4'h0)
		else $error("deselected command opened a bank");
	AST_ACT_OPENS: assert property (cmd_w == `DDRC_CMD_ACT && awake
		|=> ##1 o_bank_active[$past(i_bank_select, 2)])
		else $error("activate did not open the named bank");
	AST_PRE_ALL: assert property (cmd_w == `DDRC_CMD_PRE && awake && i_addr[10]
		|=> ##1 o_bank_active == 4'h0)
		else $error("precharge all left a bank open");
	AST_PD_ENTRY: assert property ($fell(i_clk_gate) && o_bank_active != 4'h0
		|-> ##[1:2] o_power_down)
		else $error("no active power-down after gate low");
	AST_PD_BUFFERS: assert property (o_power_down |-> !o_input_buf_en && o_ck_buf_en)
		else $error("wrong buffer enables in power-down");
	AST_SR_BUFFERS: assert property (o_self_refresh |-> !o_input_buf_en && !o_ck_buf_en)
		else $error("wrong buffer enables in self refresh");
	AST_QUIET_ASLEEP: assert property (o_power_down |-> !o_dq_oe)
		else $error("output drivers on during power-down");
	AST_RESET_STATE: assert property (disable iff (1'b0) !i_resetn
		|=> o_bank_active == 4'h0 && o_input_buf_en && !o_dq_oe)
		else $error("outputs not at reset state");
	// Main scenarios reached
	COV_READ: cover property ($rose(o_dq_oe));
	COV_PD: cover property ($rose(o_power_down));
	COV_SR: cover property ($rose(o_self_refresh));
endmodule // ddrc_cmd_props

/* File: ddrc_array_model.sv */
// Behavioural array on the far side: answers reads, sinks write words
`timescale 1ns/1ps
module ddrc_array_model (
	input  wire        i_sys_clk,
	input  wire        i_rd_req,
	input  wire [1:0]  i_bank,
	input  wire [8:0]  i_col,
	input  wire        i_stall,
	input  wire        i_wr_valid,
	input  wire [31:0] i_wr_rise,
	output reg         o_ready,
	output reg         o_rd_valid,
	output reg  [31:0] o_rd_rise,
	output reg  [31:0] o_rd_fall
);
	logic [31:0] wr_q[$];
	initial
	begin
		o_ready = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_rise = 32'h0;
		o_rd_fall = 32'h0;
	end
	// Answer a request next cycle with a word pair tagged by its address; between
	// answers the lines toggle so a stale word can never pass for fresh data
	always @(posedge i_sys_clk)
	begin
		o_ready <= !i_stall;
		o_rd_valid <= i_rd_req;
		o_rd_rise <= i_rd_req ? {21'h0, i_bank, i_col} : ~o_rd_rise;
		o_rd_fall <= i_rd_req ? ~{21'h0, i_bank, i_col} : ~o_rd_fall;
		// The design only hands a word over while ready stood, so every valid is a word
		if (i_wr_valid)
			wr_q.push_back(i_wr_rise);
	end
endmodule // ddrc_array_model

/* File: ddrc_cmd_top_tb.sv */
// Self-checking bench of the command front end
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddrc_cmd_top_tb;
	logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_reduced_page = 1'b0, i_clk_gate = 1'b1;
	logic        i_cs_n = 1'b1, i_ras_n = 1'b1, i_cas_n = 1'b1, i_we_n = 1'b1;
	logic [1:0]  i_bank_select = 2'h0;
	logic [12:0] i_addr = 13'h0;
	logic [31:0] i_wr_data_rise = 32'h0, i_wr_data_fall = 32'h0, cyc = 32'h0, c0, base;
	logic        stall = 1'b1, arr_ready, rd_valid, rd_req, wr_valid, ap;
	logic [31:0] rd_rise, rd_fall, dq_rise, wr_rise, beat;
	logic [8:0]  col, col_exp;
	logic [1:0]  bank;
	logic [12:0] row;
	logic [3:0]  bank_active;
	logic        auto_pre, dq_oe, red_drive, pdn, sref, ibuf, ckbuf;
	int          fail_count = 0, comparisons = 0, cl, k, n, first, width, al, nreq;
	always #2 i_sys_clk = ~i_sys_clk;
	// Write data tracks a cycle count, so each captured word tells when it was taken
	always @(posedge i_sys_clk)
	begin
		#1;
		cyc = cyc + 32'h1;
		i_wr_data_rise = cyc;
		i_wr_data_fall = ~cyc;
	end
	ddrc_cmd_top u_ddrc_cmd_top (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_reduced_page(i_reduced_page), .i_clk_gate(i_clk_gate), .i_cs_n(i_cs_n),
		.i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_bank_select(i_bank_select),
		.i_addr(i_addr), .i_wr_data_rise(i_wr_data_rise), .i_wr_data_fall(i_wr_data_fall),
		.i_dll_locked(1'b1), .i_arr_ready(arr_ready), .o_arr_rd_req(rd_req),
		.o_arr_wr_req(), .o_arr_bank(bank), .o_arr_row(row), .o_arr_col(col),
		.i_arr_rd_rise(rd_rise), .i_arr_rd_fall(rd_fall), .i_arr_rd_valid(rd_valid),
		.o_dq_rise(dq_rise), .o_dq_fall(), .o_dq_oe(dq_oe), .o_dqs_oe(),
		.o_wr_word_rise(wr_rise), .o_wr_word_fall(), .o_wr_word_valid(wr_valid),
		.o_auto_precharge(auto_pre), .o_bank_active(bank_active), .o_reduced_drive(red_drive),
		.o_power_down(pdn), .o_self_refresh(sref), .o_input_buf_en(ibuf), .o_ck_buf_en(ckbuf));
	ddrc_array_model u_ddrc_array_model (.i_sys_clk(i_sys_clk), .i_rd_req(rd_req),
		.i_bank(bank), .i_col(col), .i_stall(stall), .i_wr_valid(wr_valid),
		.i_wr_rise(wr_rise), .o_ready(arr_ready), .o_rd_valid(rd_valid),
		.o_rd_rise(rd_rise), .o_rd_fall(rd_fall));
	task check(input [63:0] seen, input [63:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp)
			begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
			end
		end
	endtask
	task tick(input int cnt);
		begin
			repeat (cnt) @(posedge i_sys_clk);
			#1;
		end
	endtask
	// One command on the next edge, then one no-operation cycle so that registered
	// status has settled and the next call never reassigns in the same step
	task cmd(input [3:0] code, input [1:0] b, input [12:0] a);
		begin
			{i_cs_n, i_ras_n, i_cas_n, i_we_n} = code;
			i_bank_select = b;
			i_addr = a;
			@(posedge i_sys_clk);
			c0 = cyc;
			#1;
			{i_cs_n, i_ras_n, i_cas_n, i_we_n} = `DDRC_CMD_NOP;
			tick(1);
		end
	endtask
	task mode(input b8, input [2:0] lat, input [2:0] add, input rd);
		begin
			cmd(`DDRC_CMD_MRS, 2'd0, {6'h0, lat, 1'b0, b8 ? 3'h3 : 3'h2});
			cmd(`DDRC_CMD_MRS, 2'd1, {7'h0, add, 1'b0, rd, 1'b0});
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Watchdog: the whole sequence needs well under the 5000 cycles allowed
	initial
	begin
		#20000;
		fail_count = fail_count + 1;
		tally_and_finish;
	end
	initial
	begin
		tick(6);
		i_resetn = 1'b1;
		check({bank_active, dq_oe, pdn, sref, ibuf, ckbuf, red_drive}, 10'h006);
		// Each read latency with added delay 0 or 5 and both burst lengths; start column masked by page option
		for (cl = 3; cl <= 6; cl++)
			for (k = 0; k < 4; k++)
			begin
				al = k[1] ? 5 : 0;
				i_reduced_page = k[0];
				col_exp = k[0] ? 9'h0ab : 9'h1ab;
				mode(k[0], cl[2:0], al[2:0], 1'b0);
				cmd(`DDRC_CMD_ACT, 2'd1, 13'h0123);
				cmd(`DDRC_CMD_RD, 2'd1, {2'b0, k[1], 1'b0, 9'h1ab});
				first = 0;
				width = 0;
				ap = 1'b0;
				nreq = 0;
				for (n = 1; n <= 24; n++)
				begin
					if (n > 1)
						tick(1);
					if (rd_req === 1'b1)
					begin
						check(col, nreq == 0 ? col_exp
							: {col_exp[8:3], col_exp[2:0] + 3'h4});
						nreq = nreq + 1;
					end
					if (auto_pre === 1'b1)
						ap = 1'b1;
					if (dq_oe === 1'b1 && first == 0)
					begin
						first = n;
						beat = dq_rise;
					end
					if (dq_oe === 1'b1)
						width = width + 1;
				end
				check(first, al + cl);
				check(width, k[0] ? 4 : 2);
				check(nreq, k[0] ? 2 : 1);
				check(beat, {21'h0, 2'd1, col_exp});
				check(ap, k[1]);
			end
		// Two back-to-back eight-word writes fill the buffer while the array stalls
		mode(1'b1, 3'd3, 3'd0, 1'b1);
		check(red_drive, 1'b1);
		cmd(`DDRC_CMD_ACT, 2'd2, 13'h0040);
		cmd(`DDRC_CMD_WR, 2'd2, 13'h0010);
		base = c0 + 32'd2;
		tick(2);
		cmd(`DDRC_CMD_WR, 2'd2, 13'h0018);
		tick(14);
		check(u_ddrc_array_model.wr_q.size(), 0);
		stall = 1'b0;
		tick(20);
		check(u_ddrc_array_model.wr_q.size(), 8);
		for (k = 0; k < 8; k++)
			check(u_ddrc_array_model.wr_q[k], base + k);
		// Bank bookkeeping, masking and precharge scope
		cmd(`DDRC_CMD_PRE, 2'd0, 13'h0400);
		check(bank_active, 4'h0);
		cmd(`DDRC_CMD_ACT | 4'h8, 2'd3, 13'h0001);
		check(bank_active, 4'h0);
		for (k = 0; k < 4; k++)
			cmd(`DDRC_CMD_ACT, k[1:0], 13'h0002);
		check(bank_active, 4'hf);
		cmd(`DDRC_CMD_PRE, 2'd2, 13'h0000);
		check(bank_active, 4'hb);
		// Active power-down, ignored command, then self refresh and its exit on gate high
		i_clk_gate = 1'b0;
		tick(3);
		check({pdn, sref, ibuf, ckbuf}, 4'h9);
		cmd(`DDRC_CMD_PRE, 2'd0, 13'h0400);
		check(bank_active, 4'hb);
		i_clk_gate = 1'b1;
		tick(3);
		check({pdn, ibuf}, 2'b01);
		cmd(`DDRC_CMD_PRE, 2'd0, 13'h0400);
		i_clk_gate = 1'b0;
		cmd(`DDRC_CMD_REF, 2'd0, 13'h0000);
		tick(2);
		check({pdn, sref, ibuf, ckbuf}, 4'h4);
		i_clk_gate = 1'b1;
		tick(3);
		check({sref, ibuf}, 2'b01);
		tally_and_finish;
	end
endmodule // ddrc_cmd_top_tb
bind ddrc_cmd_top ddrc_cmd_props #(.AW(AW)) u_ddrc_cmd_props (.i_sys_clk(i_sys_clk),
	.i_resetn(i_resetn), .i_clk_gate(i_clk_gate), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
	.i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_bank_select(i_bank_select), .i_addr(i_addr),
	.o_arr_rd_req(o_arr_rd_req), .o_dq_oe(o_dq_oe), .o_dqs_oe(o_dqs_oe),
	.o_bank_active(o_bank_active), .o_power_down(o_power_down),
	.o_self_refresh(o_self_refresh), .o_input_buf_en(o_input_buf_en),
	.o_ck_buf_en(o_ck_buf_en));
